// ---- hw/ptp_clock_rate_adjust.sv ----
// ptp real-time clock with rate trim, temporary adjust and sub-phase
`timescale 1ns/1ps
module ptp_clock_rate_adjust (
  input  wire logic                  clk,
  input  wire logic                  rst,
  input  wire ptp_rate_pkg::reg_req_t reg_req,
  output logic                [15:0] reg_rdata,
  output ptp_rate_pkg::rtc_time_t    rtc_now,
  output logic                       adjust_active
);
  import ptp_rate_pkg::*;

  // ---------------------------------------------------------------
  // register state
  // ---------------------------------------------------------------
  logic        continuous_adjust_enable;
  logic        clock_run_enable;
  logic        clock_snapshot_strobe;
  logic        clock_load_strobe;
  logic [15:0] rtc_nanosec_low;
  logic [13:0] rtc_nanosec_high;
  logic [15:0] rtc_seconds_low;
  logic [15:0] rtc_seconds_high;
  logic [2:0]  rtc_subphase;
  logic [15:0] rate_fraction_low;
  logic [13:0] rate_fraction_high;
  logic        rate_direction;
  logic        temp_adjust_enable;
  logic [15:0] temp_adjust_cycles_low;
  logic [15:0] temp_adjust_cycles_high;
  logic [31:0] temp_left;
  logic [31:0] run_fraction;

  // decoded writes
  logic wr_ctl;
  logic wr_ns_lo;
  logic wr_ns_hi;
  logic wr_s_lo;
  logic wr_s_hi;
  logic wr_phase;
  logic wr_rate_lo;
  logic wr_rate_hi;
  logic wr_dur_lo;
  logic wr_dur_hi;
  logic wr_time;

  always_comb begin
    wr_ctl     = 1'b0;
    wr_ns_lo   = 1'b0;
    wr_ns_hi   = 1'b0;
    wr_s_lo    = 1'b0;
    wr_s_hi    = 1'b0;
    wr_phase   = 1'b0;
    wr_rate_lo = 1'b0;
    wr_rate_hi = 1'b0;
    wr_dur_lo  = 1'b0;
    wr_dur_hi  = 1'b0;
    if (!reg_req.we) begin
      wr_ctl = 1'b0;
    end else if (reg_req.addr == ADDR_CLOCK_CTL) begin
      wr_ctl = 1'b1;
    end else if (reg_req.addr == ADDR_NANOSEC_LOW) begin
      wr_ns_lo = 1'b1;
    end else if (reg_req.addr == ADDR_NANOSEC_HIGH) begin
      wr_ns_hi = 1'b1;
    end else if (reg_req.addr == ADDR_SECONDS_LOW) begin
      wr_s_lo = 1'b1;
    end else if (reg_req.addr == ADDR_SECONDS_HIGH) begin
      wr_s_hi = 1'b1;
    end else if (reg_req.addr == ADDR_SUBPHASE) begin
      wr_phase = 1'b1;
    end else if (reg_req.addr == ADDR_RATE_LOW) begin
      wr_rate_lo = 1'b1;
    end else if (reg_req.addr == ADDR_RATE_HIGH_CTL) begin
      wr_rate_hi = 1'b1;
    end else if (reg_req.addr == ADDR_TEMP_CYC_LOW) begin
      wr_dur_lo = 1'b1;
    end else if (reg_req.addr == ADDR_TEMP_CYC_HIGH) begin
      wr_dur_hi = 1'b1;
    end
  end

  assign wr_time = wr_ns_lo | wr_ns_hi | wr_s_lo | wr_s_hi;

  // ---------------------------------------------------------------
  // rate word and adjustment selection
  // ---------------------------------------------------------------
  logic [29:0] rate_word;
  logic        temp_running;
  logic        adj_apply;

  assign rate_word = {rate_fraction_high, rate_fraction_low};
  assign temp_running = temp_adjust_enable && (temp_left != CYCLES_ZERO);
  // either temporary or continuous enable applies the trim; both use the same rate word
  assign adj_apply = (temp_running || continuous_adjust_enable)
                     && (rate_word != RATE_ZERO);

  // ---------------------------------------------------------------
  // control register: enables and self-clearing strobes
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      continuous_adjust_enable <= 1'b0;
      clock_run_enable         <= RUN_RESET;
      clock_snapshot_strobe    <= 1'b0;
      clock_load_strobe        <= 1'b0;
    end else begin
      // strobes last one cycle unless written again
      clock_snapshot_strobe <= wr_ctl && reg_req.wdata[CTL_SNAPSHOT_BIT];
      clock_load_strobe     <= wr_ctl && reg_req.wdata[CTL_LOAD_BIT];
      if (wr_ctl) begin
        continuous_adjust_enable <= reg_req.wdata[CTL_CONT_BIT];
        clock_run_enable         <= reg_req.wdata[CTL_RUN_BIT];
      end
    end
  end

  // ---------------------------------------------------------------
  // rate and duration registers
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rate_fraction_low       <= WORD_ZERO;
      rate_fraction_high      <= WORD_ZERO[RATE_HIGH_MSB:0];
      rate_direction          <= 1'b0;
      temp_adjust_cycles_low  <= WORD_ZERO;
      temp_adjust_cycles_high <= WORD_ZERO;
    end else begin
      if (wr_rate_lo) begin
        rate_fraction_low <= reg_req.wdata;
      end
      if (wr_rate_hi) begin
        rate_fraction_high <= reg_req.wdata[RATE_HIGH_MSB:0];
        rate_direction     <= reg_req.wdata[RATE_DIR_BIT];
      end
      if (wr_dur_lo) begin
        temp_adjust_cycles_low <= reg_req.wdata;
      end
      if (wr_dur_hi) begin
        temp_adjust_cycles_high <= reg_req.wdata;
      end
    end
  end

  // ---------------------------------------------------------------
  // temporary adjustment countdown
  // ---------------------------------------------------------------
  // a software write beats the self-clear landing in the same cycle
  always_ff @(posedge clk) begin
    if (rst) begin
      temp_adjust_enable <= 1'b0;
      temp_left          <= CYCLES_ZERO;
    end else if (wr_rate_hi) begin
      temp_adjust_enable <= reg_req.wdata[TEMP_EN_BIT];
      temp_left <= {temp_adjust_cycles_high, temp_adjust_cycles_low};
    end else if (temp_adjust_enable && temp_left == CYCLES_ZERO) begin
      temp_adjust_enable <= 1'b0;
    end else if (temp_running) begin
      temp_left <= temp_left - CYCLES_ONE;
    end
  end

  // ---------------------------------------------------------------
  // running clock
  // ---------------------------------------------------------------
  logic [29:0] step_ns;
  logic [31:0] step_frac;
  logic        step_wrap;

  rate_step_adder u_step (
    .nanosec       (rtc_now.nanosec),
    .fraction      (run_fraction),
    .rate          (rate_word),
    .slower        (rate_direction),
    .apply         (adj_apply),
    .next_nanosec  (step_ns),
    .next_fraction (step_frac),
    .wrap          (step_wrap)
  );

  // one advance per reference period; sub-phase is held, not resolved
  always_ff @(posedge clk) begin
    if (rst) begin
      rtc_now      <= '0;
      run_fraction <= CYCLES_ZERO;
    end else if (clock_load_strobe) begin
      rtc_now.seconds  <= {rtc_seconds_high, rtc_seconds_low};
      rtc_now.nanosec  <= {rtc_nanosec_high, rtc_nanosec_low};
      rtc_now.subphase <= rtc_subphase;
      run_fraction     <= CYCLES_ZERO;
    end else if (clock_run_enable) begin
      rtc_now.nanosec <= step_ns;
      run_fraction    <= step_frac;
      if (step_wrap) begin
        rtc_now.seconds <= rtc_now.seconds + CYCLES_ONE;
      end
    end
  end

  always_ff @(posedge clk) begin
    if (rst) begin
      adjust_active <= 1'b0;
    end else begin
      adjust_active <= adj_apply;
    end
  end

  // ---------------------------------------------------------------
  // time and phase registers (software image of the clock)
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      rtc_nanosec_low  <= WORD_ZERO;
      rtc_nanosec_high <= WORD_ZERO[NS_HIGH_MSB:0];
      rtc_seconds_low  <= WORD_ZERO;
      rtc_seconds_high <= WORD_ZERO;
    end else if (clock_snapshot_strobe) begin
      rtc_nanosec_low  <= rtc_now.nanosec[15:0];
      rtc_nanosec_high <= rtc_now.nanosec[29:16];
      rtc_seconds_low  <= rtc_now.seconds[15:0];
      rtc_seconds_high <= rtc_now.seconds[31:16];
    end else begin
      if (wr_ns_lo) begin
        rtc_nanosec_low <= reg_req.wdata;
      end
      if (wr_ns_hi) begin
        rtc_nanosec_high <= reg_req.wdata[NS_HIGH_MSB:0];
      end
      if (wr_s_lo) begin
        rtc_seconds_low <= reg_req.wdata;
      end
      if (wr_s_hi) begin
        rtc_seconds_high <= reg_req.wdata;
      end
    end
  end

  // unused codes 101-111 are coerced to zero
  always_ff @(posedge clk) begin
    if (rst) begin
      rtc_subphase <= PHASE_ZERO;
    end else if (wr_time) begin
      rtc_subphase <= PHASE_ZERO;
    end else if (wr_phase) begin
      rtc_subphase <= (reg_req.wdata[PHASE_MSB:0] > PHASE_MAX) ?
                      PHASE_ZERO : reg_req.wdata[PHASE_MSB:0];
    end else if (clock_snapshot_strobe) begin
      rtc_subphase <= rtc_now.subphase;
    end
  end

  // ---------------------------------------------------------------
  // read data, one cycle after the read request
  // ---------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (rst) begin
      reg_rdata <= WORD_ZERO;
    end else if (!reg_req.re) begin
      reg_rdata <= reg_rdata;
    end else if (reg_req.addr == ADDR_CLOCK_CTL) begin
      reg_rdata <= WORD_ZERO;
      reg_rdata[CTL_SNAPSHOT_BIT] <= clock_snapshot_strobe;
      reg_rdata[CTL_LOAD_BIT]     <= clock_load_strobe;
      reg_rdata[CTL_CONT_BIT]     <= continuous_adjust_enable;
      reg_rdata[CTL_RUN_BIT]      <= clock_run_enable;
    end else if (reg_req.addr == ADDR_NANOSEC_LOW) begin
      reg_rdata <= rtc_nanosec_low;
    end else if (reg_req.addr == ADDR_NANOSEC_HIGH) begin
      reg_rdata <= {2'b00, rtc_nanosec_high};
    end else if (reg_req.addr == ADDR_SECONDS_LOW) begin
      reg_rdata <= rtc_seconds_low;
    end else if (reg_req.addr == ADDR_SECONDS_HIGH) begin
      reg_rdata <= rtc_seconds_high;
    end else if (reg_req.addr == ADDR_SUBPHASE) begin
      reg_rdata <= {13'h0000, rtc_subphase};
    end else if (reg_req.addr == ADDR_RATE_LOW) begin
      reg_rdata <= rate_fraction_low;
    end else if (reg_req.addr == ADDR_RATE_HIGH_CTL) begin
      reg_rdata <= {rate_direction, temp_adjust_enable,
                    rate_fraction_high};
    end else if (reg_req.addr == ADDR_TEMP_CYC_LOW) begin
      reg_rdata <= temp_adjust_cycles_low;
    end else if (reg_req.addr == ADDR_TEMP_CYC_HIGH) begin
      reg_rdata <= temp_adjust_cycles_high;
    end else begin
      reg_rdata <= WORD_ZERO;
    end
  end

  // ---------------------------------------------------------------
  // assertions
  // ---------------------------------------------------------------
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);

  sequence s_temp_start;
    wr_rate_hi && reg_req.wdata[TEMP_EN_BIT];
  endsequence

  sequence s_quiet;
    !clock_load_strobe && clock_run_enable && !adj_apply && !step_wrap;
  endsequence

  AST_PHASE_RANGE: assert property (
    rtc_subphase <= PHASE_MAX)
    else $error("sub-phase holds an unused code");

  AST_PHASE_CLEAR: assert property (
    wr_time |=> rtc_subphase == PHASE_ZERO)
    else $error("time write did not zero the phase");

  AST_NOMINAL_STEP: assert property (
    s_quiet |=> rtc_now.nanosec ==
      $past(rtc_now.nanosec) + 30'(REF_PERIOD_NS))
    else $error("clock did not advance by one period");

  AST_RATE_ZERO: assert property (
    rate_word == RATE_ZERO |-> !adj_apply)
    else $error("adjustment applied with zero rate");

  AST_TEMP_SELF_CLEAR: assert property (
    temp_adjust_enable && temp_left == CYCLES_ZERO && !wr_rate_hi
    |=> !temp_adjust_enable)
    else $error("temporary enable did not clear");

  AST_TEMP_BUSY: assert property (
    temp_running && !wr_rate_hi |=> temp_adjust_enable)
    else $error("temporary enable dropped early");

  AST_TEMP_LOAD: assert property (
    s_temp_start |=> temp_adjust_enable &&
      temp_left == {$past(temp_adjust_cycles_high),
                    $past(temp_adjust_cycles_low)})
    else $error("duration not loaded on start");

  AST_SNAPSHOT: assert property (
    clock_snapshot_strobe |=>
      {rtc_seconds_high, rtc_seconds_low} == $past(rtc_now.seconds))
    else $error("snapshot missed the running seconds");

  AST_LOAD: assert property (
    clock_load_strobe |=>
      rtc_now.nanosec == $past({rtc_nanosec_high, rtc_nanosec_low}))
    else $error("load did not copy nanoseconds");

  AST_STROBE_CLEAR: assert property (
    clock_snapshot_strobe && !wr_ctl |=> !clock_snapshot_strobe)
    else $error("snapshot strobe did not self-clear");

endmodule : ptp_clock_rate_adjust

// ---- hw/ptp_rate_pkg.sv ----
// register map, field layout and timing constants for the ptp rate block
package ptp_rate_pkg;

  // ---------------------------------------------------------------
  // timing
  // ---------------------------------------------------------------
  localparam int CLK_FREQ_HZ   = 25_000_000;
  localparam int REF_PERIOD_NS = 40;
  localparam int SUBPHASE_NS   = 8;
  localparam int REF_CYCLES    = (REF_PERIOD_NS * (CLK_FREQ_HZ / 1000))
                                 / 1_000_000;
  localparam int NS_PER_SEC    = 1_000_000_000;
  localparam int FRAC_BITS     = 32;

  // fixed point: nanoseconds above bit 32, 2^-32 ns below
  localparam logic [63:0] STEP_FX = 64'(REF_PERIOD_NS) << FRAC_BITS;
  localparam logic [63:0] WRAP_FX = 64'(NS_PER_SEC) << FRAC_BITS;

  // ---------------------------------------------------------------
  // register offsets (16-bit registers, byte addresses)
  // ---------------------------------------------------------------
  localparam logic [10:0] ADDR_CLOCK_CTL     = 11'h600;
  localparam logic [10:0] ADDR_NANOSEC_LOW   = 11'h604;
  localparam logic [10:0] ADDR_NANOSEC_HIGH  = 11'h606;
  localparam logic [10:0] ADDR_SECONDS_LOW   = 11'h608;
  localparam logic [10:0] ADDR_SECONDS_HIGH  = 11'h60A;
  localparam logic [10:0] ADDR_SUBPHASE      = 11'h60C;
  localparam logic [10:0] ADDR_RATE_LOW      = 11'h610;
  localparam logic [10:0] ADDR_RATE_HIGH_CTL = 11'h612;
  localparam logic [10:0] ADDR_TEMP_CYC_LOW  = 11'h614;
  localparam logic [10:0] ADDR_TEMP_CYC_HIGH = 11'h616;

  // ---------------------------------------------------------------
  // field positions
  // ---------------------------------------------------------------
  localparam int CTL_SNAPSHOT_BIT = 4;
  localparam int CTL_LOAD_BIT     = 3;
  localparam int CTL_CONT_BIT     = 2;
  localparam int CTL_RUN_BIT      = 1;
  localparam int RATE_DIR_BIT     = 15;
  localparam int TEMP_EN_BIT      = 14;
  localparam int RATE_HIGH_MSB    = 13;
  localparam int NS_HIGH_MSB      = 13;
  localparam int PHASE_MSB        = 2;

  // ---------------------------------------------------------------
  // reset values and codes
  // ---------------------------------------------------------------
  localparam logic        RUN_RESET   = 1'b1;
  localparam logic [2:0]  PHASE_ZERO  = 3'h0;
  localparam logic [2:0]  PHASE_MAX   = 3'h4;
  localparam logic [15:0] WORD_ZERO   = 16'h0000;
  localparam logic [29:0] RATE_ZERO   = 30'h0000_0000;
  localparam logic [31:0] CYCLES_ZERO = 32'h0000_0000;
  localparam logic [31:0] CYCLES_ONE  = 32'h0000_0001;

  // host register request
  typedef struct packed {
    logic [10:0] addr;
    logic [15:0] wdata;
    logic        we;
    logic        re;
  } reg_req_t;

  // running or captured time
  typedef struct packed {
    logic [31:0] seconds;
    logic [29:0] nanosec;
    logic [2:0]  subphase;
  } rtc_time_t;

endpackage : ptp_rate_pkg

// ---- hw/rate_step_adder.sv ----
// one reference-cycle advance of the nanosecond count with rate trim
`timescale 1ns/1ps
module rate_step_adder
  import ptp_rate_pkg::*;
(
  input  wire logic [29:0] nanosec,
  input  wire logic [31:0] fraction,
  input  wire logic [29:0] rate,
  input  wire logic        slower,
  input  wire logic        apply,
  output logic      [29:0] next_nanosec,
  output logic      [31:0] next_fraction,
  output logic             wrap
);

  // ---------------------------------------------------------------
  // nominal period plus or minus the trim, carried through the fraction
  // ---------------------------------------------------------------
  logic [63:0] now_fx;
  logic [63:0] step_fx;
  logic [63:0] sum_fx;

  // rate is below one ns, so a slower step can never underflow
  always_comb begin
    now_fx  = {2'b00, nanosec, fraction};
    step_fx = STEP_FX;
    if (apply && slower) begin
      step_fx = STEP_FX - {34'h0, rate};
    end else if (apply) begin
      step_fx = STEP_FX + {34'h0, rate};
    end
    sum_fx = now_fx + step_fx;
    wrap   = (sum_fx >= WRAP_FX);
    if (wrap) begin
      sum_fx = sum_fx - WRAP_FX;
    end
    next_nanosec  = sum_fx[61:32];
    next_fraction = sum_fx[31:0];
  end

endmodule : rate_step_adder

// ---- tb/testbench.sv ----
// self-checking bench for the ptp rate trim block
`timescale 1ns/1ps
module testbench;
  import ptp_rate_pkg::*;

  // ---------------------------------------------------------------
  // signals and counters
  // ---------------------------------------------------------------
  typedef struct packed {
    logic [10:0] addr;
    logic [15:0] wdata;
    logic [15:0] expect_rd;
  } row_t;

  logic        clk;
  logic        rst;
  reg_req_t    req;
  logic [15:0] rdata;
  rtc_time_t   now;
  logic        active;
  int          n_errors;
  int          compares;
  int          cyc;
  int          c0;
  logic [15:0] v;
  logic [29:0] s0;

  // write/read pairs; the expected value shows masking and refusals
  row_t rows [8] = '{
    '{11'h610, 16'hFFFF, 16'hFFFF}, '{11'h612, 16'h3FFF, 16'h3FFF},
    '{11'h614, 16'hA5A5, 16'hA5A5}, '{11'h616, 16'h5A5A, 16'h5A5A},
    '{11'h60C, 16'h0004, 16'h0004}, '{11'h60C, 16'hFFFD, 16'h0000},
    '{11'h606, 16'hFFFF, 16'h3FFF}, '{11'h618, 16'h1234, 16'h0000}};
  logic [10:0] time_regs [4] = '{11'h604, 11'h606, 11'h608, 11'h60A};

  ptp_clock_rate_adjust dut_u (
    .clk           (clk),
    .rst           (rst),
    .reg_req       (req),
    .reg_rdata     (rdata),
    .rtc_now       (now),
    .adjust_active (active)
  );

  // ---------------------------------------------------------------
  // clock, cycle count and hang guard
  // ---------------------------------------------------------------
  always #20 clk = ~clk;

  // a hang in a poll loop would otherwise run forever
  always @(posedge clk) begin
    cyc <= cyc + 1;
    if (cyc >= 4000) begin
      n_errors = n_errors + 1;
      $display("MISMATCH at %0t: run did not finish", $time);
      final_report();
    end
  end

  // ---------------------------------------------------------------
  // bus tasks; every request is followed by one idle edge
  // ---------------------------------------------------------------
  task automatic chk(input logic [63:0] got, input logic [63:0] exp,
                     input string msg);
    compares = compares + 1;
    if (got !== exp) begin
      n_errors = n_errors + 1;
      $display("MISMATCH at %0t: %s got %0h exp %0h", $time, msg, got, exp);
    end
  endtask : chk

  task automatic wr(input logic [10:0] a, input logic [15:0] d);
    req.addr  = a;
    req.wdata = d;
    req.we    = 1'b1;
    @(posedge clk);
    #1;
    req.we = 1'b0;
    @(posedge clk);
    #1;
  endtask : wr

  task automatic rd(input logic [10:0] a, output logic [15:0] d);
    req.addr = a;
    req.re   = 1'b1;
    @(posedge clk);
    #1;
    d      = rdata;
    req.re = 1'b0;
    @(posedge clk);
    #1;
  endtask : rd

  task automatic rdchk(input logic [10:0] a, input logic [15:0] exp);
    logic [15:0] d;
    rd(a, d);
    chk(d, exp, "register read");
  endtask : rdchk

  // advance of the nanosecond count over eight quiet edges
  task automatic delta8(input int exp);
    logic [29:0] a;
    a = now.nanosec;
    repeat (8) @(posedge clk);
    #1;
    chk(now.nanosec - a, exp[29:0], "advance over eight cycles");
  endtask : delta8

  task automatic final_report();
    $display("errors %0d compares %0d", n_errors, compares);
    if (n_errors == 0 && compares > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask : final_report

  // ---------------------------------------------------------------
  // main sequence
  // ---------------------------------------------------------------
  initial begin
    clk      = 1'b0;
    rst      = 1'b1;
    req      = '0;
    n_errors = 0;
    compares = 0;
    cyc      = 0;
    repeat (6) @(posedge clk);
    #1;
    rst = 1'b0;

    // reset values, control shows only the run enable
    rdchk(ADDR_CLOCK_CTL, 16'h0002);
    rdchk(ADDR_SUBPHASE, 16'h0000);
    rdchk(ADDR_RATE_LOW, 16'h0000);
    rdchk(ADDR_RATE_HIGH_CTL, 16'h0000);
    rdchk(ADDR_TEMP_CYC_LOW, 16'h0000);
    rdchk(ADDR_TEMP_CYC_HIGH, 16'h0000);

    // ordinary register cases from the table
    for (int i = 0; i < 8; i++) begin
      wr(rows[i].addr, rows[i].wdata);
      rdchk(rows[i].addr, rows[i].expect_rd);
    end

    // a cpu write to any time word zeroes the phase field
    for (int i = 0; i < 4; i++) begin
      wr(ADDR_SUBPHASE, 16'h0003);
      wr(time_regs[i], 16'h0000);
      rdchk(ADDR_SUBPHASE, 16'h0000);
    end

    // load a known time, then let it run untrimmed
    wr(ADDR_SECONDS_LOW, 16'h0012);
    wr(ADDR_NANOSEC_LOW, 16'h0100);
    wr(ADDR_SUBPHASE, 16'h0002);
    wr(ADDR_RATE_LOW, 16'h0000);
    wr(ADDR_RATE_HIGH_CTL, 16'h0000);
    wr(ADDR_CLOCK_CTL, 16'h000A);
    chk(now.seconds, 32'h12, "loaded seconds");
    chk(now.subphase, 3'h2, "loaded phase");
    chk(now.nanosec <= 30'h100 + 30'd120, 1'b1, "loaded ns");
    delta8(320);

    // snapshot; strobe clears itself and registers hold the time
    wr(ADDR_CLOCK_CTL, 16'h0012);
    rdchk(ADDR_CLOCK_CTL, 16'h0002);
    rdchk(ADDR_SECONDS_LOW, 16'h0012);
    rdchk(ADDR_SUBPHASE, 16'h0002);
    rd(ADDR_NANOSEC_LOW, v);
    chk((v - 16'h0100) % 16'd40, 16'h0, "snapshot ns step");

    // continuous mode with zero rate does nothing
    wr(ADDR_CLOCK_CTL, 16'h0006);
    delta8(320);
    chk(active, 1'b0, "idle with zero rate");

    // smallest rate still counts as an adjustment
    wr(ADDR_RATE_LOW, 16'h0001);
    wr(ADDR_RATE_LOW, 16'h0000);
    wr(ADDR_RATE_LOW, 16'h0001);
    chk(active, 1'b1, "one lsb rate active");
    wr(ADDR_RATE_LOW, 16'h0000);

    // 1/8 ns per cycle sums to exactly one ns over eight cycles
    wr(ADDR_RATE_HIGH_CTL, 16'h2000);
    chk(active, 1'b1, "continuous active");
    delta8(321);
    wr(ADDR_RATE_HIGH_CTL, 16'hA000);
    delta8(319);

    // temporary mode for eight cycles, faster
    wr(ADDR_CLOCK_CTL, 16'h0002);
    wr(ADDR_TEMP_CYC_LOW, 16'h0008);
    wr(ADDR_TEMP_CYC_HIGH, 16'h0000);
    wr(ADDR_RATE_HIGH_CTL, 16'h2000);
    s0 = now.nanosec;
    c0 = cyc;
    wr(ADDR_RATE_HIGH_CTL, 16'h6000);
    chk(active, 1'b1, "temporary running");
    rdchk(ADDR_RATE_HIGH_CTL, 16'h6000);
    repeat (12) @(posedge clk);
    #1;
    rdchk(ADDR_RATE_HIGH_CTL, 16'h2000);
    chk(active, 1'b0, "temporary finished");
    chk(now.nanosec - s0, 30'(40 * (cyc - c0) + 1), "temp ns");

    // temporary and continuous together; continuous carries on
    wr(ADDR_CLOCK_CTL, 16'h0006);
    wr(ADDR_RATE_HIGH_CTL, 16'hE000);
    rdchk(ADDR_RATE_HIGH_CTL, 16'hE000);
    repeat (12) @(posedge clk);
    #1;
    rdchk(ADDR_RATE_HIGH_CTL, 16'hA000);
    chk(active, 1'b1, "continuous resumed");
    delta8(319);

    // long temporary adjustment aborted by software
    wr(ADDR_CLOCK_CTL, 16'h0002);
    wr(ADDR_TEMP_CYC_HIGH, 16'h0001);
    wr(ADDR_RATE_HIGH_CTL, 16'h6000);
    rdchk(ADDR_RATE_HIGH_CTL, 16'h6000);
    wr(ADDR_RATE_HIGH_CTL, 16'h2000);
    @(posedge clk);
    #1;
    chk(active, 1'b0, "aborted temp");
    delta8(320);

    // second reset in mid-run of a temporary adjustment
    wr(ADDR_RATE_HIGH_CTL, 16'h6000);
    rst = 1'b1;
    repeat (2) @(posedge clk);
    #1;
    rst = 1'b0;
    chk(active, 1'b0, "reset clears trim");
    rdchk(ADDR_RATE_HIGH_CTL, 16'h0000);
    rdchk(ADDR_TEMP_CYC_HIGH, 16'h0000);
    final_report();
  end

endmodule : testbench
